// File: lbsr_regs.sv
`timescale 1ns/1ps
module lbsr_regs
  import lbsr_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic NRST_I,
  input wire logic WR_EN_I,
  input wire logic RD_EN_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [8:0] WDATA_I,
  output logic [8:0] RDATA_O,
  output logic RVALID_O,
  input wire logic TEMP_VALID_I,
  input wire logic [7:0] TEMP_CODE_I,
  input wire logic CONV_START_I,
  input wire logic CONV_DONE_I,
  input wire logic [7:0] CONV_CODE_I,
  input wire logic CH1_DIMMING_INPUT_I,
  output logic [7:0] CH2_PEAK_DAC_O,
  output logic [7:0] CH2_OFF_DAC_O,
  output logic [7:0] CH1_MAXOFF_DAC_O,
  output logic [7:0] CH2_MAXOFF_DAC_O,
  output logic CH1_MAXOFF_END_O,
  output logic CH2_MAXOFF_END_O,
  output logic CH1_SWITCH_EN_O,
  output logic CH2_SWITCH_EN_O
);
  logic [7:0] ch2_peak_threshold_ff;
  logic [7:0] ch2_off_time_ff;
  logic [7:0] ch1_max_off_time_ff;
  logic [7:0] ch2_max_off_time_ff;
  logic [7:0] die_temperature_ff;
  logic [7:0] sample_ff;
  logic dim_bit_ff;
  logic dim_at_start_ff;
  logic [8:0] rdata_ff;
  logic rvalid_ff;
  logic [7:0] peak_dac_ff;
  logic [4:0] settle_ff;
  logic start_ff;
  logic en1_ff;
  logic en2_ff;
  logic busy1;
  logic busy2;
  logic done1;
  logic done2;
  // ----------------------------------------
  // host writes to setpoints
  // ----------------------------------------
  // only bits 7:0 are stored; bit 8 is dropped
  always_ff @(posedge MCLK_I)
  begin
    if (!NRST_I)
    begin
      ch2_peak_threshold_ff <= RST_SETPOINT;
      ch2_off_time_ff <= RST_SETPOINT;
      ch1_max_off_time_ff <= RST_SETPOINT;
      ch2_max_off_time_ff <= RST_SETPOINT;
    end
    else if (WR_EN_I)
    begin
      unique case (ADDR_I)
        ADDR_CH2_PEAK: ch2_peak_threshold_ff <= WDATA_I[7:0];
        ADDR_CH2_OFF: ch2_off_time_ff <= WDATA_I[7:0];
        ADDR_CH1_MAXOFF: ch1_max_off_time_ff <= WDATA_I[7:0];
        ADDR_CH2_MAXOFF: ch2_max_off_time_ff <= WDATA_I[7:0];
        default:
        begin
        end
      endcase
    end
  end
  // ----------------------------------------
  // peak dac follows after settle time
  // ----------------------------------------
  // code is millivolts; analog side divides by 1000
  always_ff @(posedge MCLK_I)
  begin
    if (!NRST_I)
    begin
      peak_dac_ff <= RST_SETPOINT;
      settle_ff <= '0;
    end
    else if (WR_EN_I && ADDR_I == ADDR_CH2_PEAK)
    begin
      settle_ff <= 5'(DAC_SETTLE_CYC);
    end
    else if (settle_ff > 5'h01)
    begin
      settle_ff <= settle_ff - 5'h01;
    end
    else if (settle_ff == 5'h01)
    begin
      settle_ff <= '0;
      peak_dac_ff <= ch2_peak_threshold_ff;
    end
  end
  // ----------------------------------------
  // readback captures
  // ----------------------------------------
  always_ff @(posedge MCLK_I)
  begin
    if (!NRST_I)
    begin
      die_temperature_ff <= RST_READBACK;
      sample_ff <= RST_READBACK;
      dim_bit_ff <= 1'b0;
      dim_at_start_ff <= 1'b0;
    end
    else
    begin
      if (TEMP_VALID_I)
        die_temperature_ff <= TEMP_CODE_I;
      if (CONV_START_I)
        dim_at_start_ff <= CH1_DIMMING_INPUT_I;
      if (CONV_DONE_I)
      begin
        sample_ff <= CONV_CODE_I;
        dim_bit_ff <= CONV_START_I ? CH1_DIMMING_INPUT_I : dim_at_start_ff;
      end
    end
  end
  // ----------------------------------------
  // read port
  // ----------------------------------------
  // reserved bit 8 reads zero; unmapped reads zero
  always_ff @(posedge MCLK_I)
  begin
    if (!NRST_I)
    begin
      rdata_ff <= '0;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= RD_EN_I;
      if (RD_EN_I)
      begin
        unique case (ADDR_I)
          ADDR_CH2_PEAK: rdata_ff <= {1'b0, ch2_peak_threshold_ff};
          ADDR_CH2_OFF: rdata_ff <= {1'b0, ch2_off_time_ff};
          ADDR_CH1_MAXOFF: rdata_ff <= {1'b0, ch1_max_off_time_ff};
          ADDR_CH2_MAXOFF: rdata_ff <= {1'b0, ch2_max_off_time_ff};
          ADDR_DIE_TEMP: rdata_ff <= {1'b0, die_temperature_ff};
          ADDR_CH1_SAMPLE: rdata_ff <= {dim_bit_ff, sample_ff};
          default: rdata_ff <= '0;
        endcase
      end
    end
  end
  // ----------------------------------------
  // start-up gating by max off-time
  // ----------------------------------------
  // off period itself is analog: code / (2.136e6 * led voltage)
  always_ff @(posedge MCLK_I)
  begin
    if (!NRST_I)
    begin
      start_ff <= 1'b1;
      en1_ff <= 1'b0;
      en2_ff <= 1'b0;
    end
    else
    begin
      start_ff <= 1'b0;
      if (done1)
        en1_ff <= 1'b1;
      if (done2)
        en2_ff <= 1'b1;
    end
  end
  lbsr_maxoff_timer u_t1 (
    .clk_i(MCLK_I),
    .nrst_i(NRST_I),
    .start_i(start_ff),
    .code_i(ch1_max_off_time_ff),
    .busy_o(busy1),
    .done_o(done1)
  );
  lbsr_maxoff_timer u_t2 (
    .clk_i(MCLK_I),
    .nrst_i(NRST_I),
    .start_i(start_ff),
    .code_i(ch2_max_off_time_ff),
    .busy_o(busy2),
    .done_o(done2)
  );
  assign RDATA_O = rdata_ff;
  assign RVALID_O = rvalid_ff;
  assign CH2_PEAK_DAC_O = peak_dac_ff;
  assign CH2_OFF_DAC_O = ch2_off_time_ff;
  assign CH1_MAXOFF_DAC_O = ch1_max_off_time_ff;
  assign CH2_MAXOFF_DAC_O = ch2_max_off_time_ff;
  assign CH1_MAXOFF_END_O = done1;
  assign CH2_MAXOFF_END_O = done2;
  assign CH1_SWITCH_EN_O = en1_ff;
  assign CH2_SWITCH_EN_O = en2_ff;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  // helper: ch2 startup busy length and the code the timer was loaded with
  logic [MAXOFF_CNT_W-1:0] busy2_len_ff;
  logic [7:0] code2_start_ff;
  always_ff @(posedge MCLK_I)
  begin
    if (!NRST_I)
    begin
      busy2_len_ff <= '0;
      code2_start_ff <= RST_SETPOINT;
    end
    else
    begin
      busy2_len_ff <= busy2 ? busy2_len_ff + MAXOFF_CNT_W'(1) : '0;
      if (start_ff)
        code2_start_ff <= ch2_max_off_time_ff;
    end
  end
  rsvd_zero_a: assert property (
    @(posedge MCLK_I) disable iff (!NRST_I)
    rvalid_ff && $past(ADDR_I) != ADDR_CH1_SAMPLE |-> !rdata_ff[8])
    else $error("reserved bit read nonzero");
  peak_settle_a: assert property (
    @(posedge MCLK_I) disable iff (!NRST_I)
    WR_EN_I && ADDR_I == ADDR_CH2_PEAK ##1
    !(WR_EN_I && ADDR_I == ADDR_CH2_PEAK) [*8] |->
    ##13 peak_dac_ff == ch2_peak_threshold_ff)
    else $error("peak dac not updated after settle");
  off_wr_a: assert property (
    @(posedge MCLK_I) disable iff (!NRST_I)
    WR_EN_I && ADDR_I == ADDR_CH2_OFF |=>
    ch2_off_time_ff == $past(WDATA_I[7:0]))
    else $error("off-time write lost");
  maxoff_wr_a: assert property (
    @(posedge MCLK_I) disable iff (!NRST_I)
    WR_EN_I && ADDR_I == ADDR_CH1_MAXOFF |=>
    ch1_max_off_time_ff == $past(WDATA_I[7:0]))
    else $error("max off-time write lost");
  no_early_sw_a: assert property (
    @(posedge MCLK_I) disable iff (!NRST_I)
    busy1 |-> !en1_ff)
    else $error("switching before max off-time");
  no_early_sw2_a: assert property (
    @(posedge MCLK_I) disable iff (!NRST_I)
    busy2 |-> !en2_ff)
    else $error("ch2 switching before max off-time");
  timer_len_a: assert property (
    @(posedge MCLK_I) disable iff (!NRST_I)
    $fell(busy2) |-> busy2_len_ff == ((code2_start_ff == 8'h00) ?
    MAXOFF_CNT_W'(1) : MAXOFF_CNT_W'(code2_start_ff * MAXOFF_STEP_CYC)))
    else $error("max off timer length wrong");
  temp_cap_a: assert property (
    @(posedge MCLK_I) disable iff (!NRST_I)
    TEMP_VALID_I |=> die_temperature_ff == $past(TEMP_CODE_I))
    else $error("temperature not captured");
  dim_cap_a: assert property (
    @(posedge MCLK_I) disable iff (!NRST_I)
    CONV_START_I && CONV_DONE_I |=>
    dim_bit_ff == $past(CH1_DIMMING_INPUT_I))
    else $error("dimming level not captured");
  ro_keep_a: assert property (
    @(posedge MCLK_I) disable iff (!NRST_I)
    !TEMP_VALID_I |=> $stable(die_temperature_ff))
    else $error("read-only register changed");
endmodule : lbsr_regs

// File: lbsr_pkg.sv
// Contract
// - peak threshold reg at 04h, bits 7:0 rw reset 80h, bit 8 reads zero
// - new peak code accepted any time, analog value follows about 1 us later
// - peak code is trip voltage in millivolts, code over 1000 gives volts
// - channel 2 off-time reg at 06h, 8-bit rw reset 80h, bit 8 zero
// - off period is code over 2.136e6 times channel led voltage
// - max off-time regs at 07h and 08h, 8-bit rw reset 80h, bit 8 zero
// - parallel max off timer lasts code times 251 ns, voltage independent; the timer counts code times 6 cycles (300 ns) instead
// - after reset wait programmed max off-time before first switching cycle
// - read-only die temperature reg at 09h, reset zero, latest adc code
// - read-only ch1 latest sample reg at 0Ah, reset zero
// - bit 8 holds dimming level at conversion start, bits 7:0 result
package lbsr_pkg;
  localparam int unsigned CLK_MHZ = 20;
  localparam logic [3:0] ADDR_CH2_PEAK = 4'h4;
  localparam logic [3:0] ADDR_CH2_OFF = 4'h6;
  localparam logic [3:0] ADDR_CH1_MAXOFF = 4'h7;
  localparam logic [3:0] ADDR_CH2_MAXOFF = 4'h8;
  localparam logic [3:0] ADDR_DIE_TEMP = 4'h9;
  localparam logic [3:0] ADDR_CH1_SAMPLE = 4'ha;
  localparam logic [7:0] RST_SETPOINT = 8'h80;
  localparam logic [7:0] RST_READBACK = 8'h00;
  // analog settle time after a peak code write
  localparam int unsigned DAC_SETTLE_NS = 1000;
  localparam int unsigned DAC_SETTLE_CYC = DAC_SETTLE_NS * CLK_MHZ / 1000;
  // max off-time step, 251 ns rounded up to whole cycles
  localparam int unsigned MAXOFF_STEP_NS = 251;
  localparam int unsigned MAXOFF_STEP_CYC =
    (MAXOFF_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned MAXOFF_CNT_W = 13;
endpackage : lbsr_pkg

// File: lbsr_maxoff_timer.sv
`timescale 1ns/1ps
module lbsr_maxoff_timer
  import lbsr_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire logic [7:0] code_i,
  output logic busy_o,
  output logic done_o
);
  logic [MAXOFF_CNT_W-1:0] cnt_ff;
  logic busy_ff;
  logic done_ff;
  assign busy_o = busy_ff;
  assign done_o = done_ff;
  // ----------------------------------------
  // code times 6 cycles (251 ns rounded up), independent of voltage
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      cnt_ff <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else if (start_i)
    begin
      cnt_ff <= MAXOFF_CNT_W'(code_i * MAXOFF_STEP_CYC);
      busy_ff <= 1'b1;
      done_ff <= 1'b0;
    end
    else if (busy_ff)
    begin
      if (cnt_ff <= MAXOFF_CNT_W'(1))
      begin
        busy_ff <= 1'b0;
        done_ff <= 1'b1;
        cnt_ff <= '0;
      end
      else
      begin
        cnt_ff <= cnt_ff - MAXOFF_CNT_W'(1);
      end
    end
    else
    begin
      done_ff <= 1'b0;
    end
  end
endmodule : lbsr_maxoff_timer

// File: lbsr_adc_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// adc and dimming pin stand-in
// ----------------------------------------
module lbsr_adc_model
(
  input wire logic clk_i,
  output logic temp_valid_o,
  output logic [7:0] temp_code_o,
  output logic conv_start_o,
  output logic conv_done_o,
  output logic [7:0] conv_code_o,
  output logic dim_o
);
  initial
  begin
    temp_valid_o = 1'b0;
    temp_code_o = 8'h00;
    conv_start_o = 1'b0;
    conv_done_o = 1'b0;
    conv_code_o = 8'h00;
    dim_o = 1'b0;
  end
  // code lines show the inverse once the strobe drops
  task automatic temp(input logic [7:0] c);
    @(posedge clk_i);
    #1;
    temp_valid_o = 1'b1;
    temp_code_o = c;
    @(posedge clk_i);
    #1;
    temp_valid_o = 1'b0;
    temp_code_o = ~c;
  endtask : temp
  // dim level flips after start, so a late capture is caught
  task automatic conv(input logic d, input logic [7:0] c);
    @(posedge clk_i);
    #1;
    dim_o = d;
    conv_start_o = 1'b1;
    @(posedge clk_i);
    #1;
    conv_start_o = 1'b0;
    dim_o = ~d;
    repeat (3) @(posedge clk_i);
    #1;
    conv_done_o = 1'b1;
    conv_code_o = c;
    @(posedge clk_i);
    #1;
    conv_done_o = 1'b0;
    conv_code_o = ~c;
  endtask : conv
  // start and done in one cycle: the live level is the one kept
  task automatic conv_now(input logic d, input logic [7:0] c);
    @(posedge clk_i);
    #1;
    dim_o = d;
    conv_start_o = 1'b1;
    conv_done_o = 1'b1;
    conv_code_o = c;
    @(posedge clk_i);
    #1;
    conv_start_o = 1'b0;
    conv_done_o = 1'b0;
    dim_o = ~d;
    conv_code_o = ~c;
  endtask : conv_now
endmodule : lbsr_adc_model

// File: test_led_buck_setpoint_regs.sv
`timescale 1ns/1ps
module test_led_buck_setpoint_regs;
  import lbsr_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [8:0] wdata = 9'h000;
  logic [8:0] rdata;
  logic rvalid;
  logic tv, cs, cd, dim, sw1, sw2, end1, end2;
  logic [7:0] tc, cc, pk, off, mo1, mo2;
  int error_cnt = 0;
  int tests_run = 0;
  int n;
  int e_at = 0;
  always #25 mclk = ~mclk;
  lbsr_adc_model adc_u (.clk_i(mclk), .temp_valid_o(tv), .temp_code_o(tc),
    .conv_start_o(cs), .conv_done_o(cd), .conv_code_o(cc), .dim_o(dim));
  lbsr_regs dut_u (.MCLK_I(mclk), .NRST_I(nrst), .WR_EN_I(wr_en),
    .RD_EN_I(rd_en), .ADDR_I(addr), .WDATA_I(wdata), .RDATA_O(rdata),
    .RVALID_O(rvalid), .TEMP_VALID_I(tv), .TEMP_CODE_I(tc),
    .CONV_START_I(cs), .CONV_DONE_I(cd), .CONV_CODE_I(cc),
    .CH1_DIMMING_INPUT_I(dim), .CH2_PEAK_DAC_O(pk), .CH2_OFF_DAC_O(off),
    .CH1_MAXOFF_DAC_O(mo1), .CH2_MAXOFF_DAC_O(mo2), .CH1_MAXOFF_END_O(end1),
    .CH2_MAXOFF_END_O(end2), .CH1_SWITCH_EN_O(sw1), .CH2_SWITCH_EN_O(sw2));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [8:0] d);
    @(posedge mclk);
    #1;
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(posedge mclk);
    #1;
    wr_en = 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [8:0] e);
    @(posedge mclk);
    #1;
    rd_en = 1'b1;
    addr = a;
    @(posedge mclk);
    #1;
    rd_en = 1'b0;
    chk("rvalid", 9'h001, {8'h00, rvalid});
    chk("rdata", e, rdata);
  endtask : rd
  task automatic complete_run;
    $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (12) @(posedge mclk);
    #1;
    nrst = 1'b1;
    // startup wait of 128 steps of 6 cycles
    n = 0;
    while (sw1 !== 1'b1 && n < 1000)
    begin
      @(posedge mclk);
      #1;
      n++;
      if (end1 === 1'b1 && end2 === 1'b1)
        e_at = n;
    end
    chk("startup_timeout", 9'h001, {8'h00, n < 1000});
    chk("startup", 9'h001, {8'h00, n >= 768 && n <= 772});
    chk("maxoff_end", 9'h001, {8'h00, e_at == n - 1});
    chk("ch2_switch", 9'h001, {8'h00, sw2});
    $display("test startup done");
    rd(ADDR_CH2_PEAK, 9'h080);
    rd(ADDR_CH2_OFF, 9'h080);
    rd(ADDR_CH1_MAXOFF, 9'h080);
    rd(ADDR_CH2_MAXOFF, 9'h080);
    rd(ADDR_DIE_TEMP, 9'h000);
    rd(ADDR_CH1_SAMPLE, 9'h000);
    $display("test reset_values done");
    wr(ADDR_CH2_PEAK, 9'h1a5);
    repeat (19) @(posedge mclk);
    #1;
    chk("peak_early", 9'h080, {1'b0, pk});
    @(posedge mclk);
    #1;
    chk("peak_late", 9'h0a5, {1'b0, pk});
    rd(ADDR_CH2_PEAK, 9'h0a5);
    wr(ADDR_CH2_PEAK, 9'h0ff);
    rd(ADDR_CH2_PEAK, 9'h0ff);
    wr(ADDR_CH2_OFF, 9'h1ff);
    chk("off_dac", 9'h0ff, {1'b0, off});
    rd(ADDR_CH2_OFF, 9'h0ff);
    wr(ADDR_CH1_MAXOFF, 9'h0c1);
    wr(ADDR_CH2_MAXOFF, 9'h1fe);
    chk("maxoff_dac1", 9'h0c1, {1'b0, mo1});
    chk("maxoff_dac2", 9'h0fe, {1'b0, mo2});
    rd(ADDR_CH1_MAXOFF, 9'h0c1);
    rd(ADDR_CH2_MAXOFF, 9'h0fe);
    wr(4'hf, 9'h0ff);
    rd(4'hf, 9'h000);
    rd(4'h0, 9'h000);
    $display("test setpoints done");
    adc_u.temp(8'h5a);
    rd(ADDR_DIE_TEMP, 9'h05a);
    wr(ADDR_DIE_TEMP, 9'h1ff);
    rd(ADDR_DIE_TEMP, 9'h05a);
    adc_u.conv(1'b1, 8'h3c);
    rd(ADDR_CH1_SAMPLE, 9'h13c);
    adc_u.conv(1'b0, 8'hc3);
    wr(ADDR_CH1_SAMPLE, 9'h155);
    rd(ADDR_CH1_SAMPLE, 9'h0c3);
    adc_u.conv_now(1'b1, 8'h69);
    rd(ADDR_CH1_SAMPLE, 9'h169);
    $display("test readback done");
    complete_run();
  end
endmodule : test_led_buck_setpoint_regs
